// [bench/event_source.sv]
`timescale 1ns/1ps
module event_source
(
  // Clock
  input  wire logic clock,
  // Pins toward the counter
  output logic      upperEventPin,
  output logic      lowerEventPin,
  output logic      gateInterruptPin,
  output logic      pwmGateOutput
);

  // ==========================================================
  // Pin drivers
  initial
  begin
    upperEventPin    = 1'b1;
    lowerEventPin    = 1'b1;
    gateInterruptPin = 1'b1;
    pwmGateOutput    = 1'b1;
  end

  // Idle high, so each pulse is one fall then one rise;
  // w of at least 2 lets the synchroniser see every level
  task automatic pulse(input logic upper, input int n, input int w);
    repeat (n)
    begin
      if (upper) upperEventPin <= 1'b0;
      else lowerEventPin <= 1'b0;
      repeat (w) @(posedge clock);
      if (upper) upperEventPin <= 1'b1;
      else lowerEventPin <= 1'b1;
      repeat (w) @(posedge clock);
    end
  endtask : pulse

  task automatic setGate(input logic g, input logic p);
    gateInterruptPin <= g;
    pwmGateOutput    <= p;
    @(posedge clock);
  endtask : setGate

endmodule : event_source

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import event_counter_pkg::*;

  // ==========================================================
  // Signals
  logic       clock    = 1'b0;
  logic       rst_n    = 1'b0;
  logic       ce       = 1'b1;
  reg_req_s   regReq   = '0;
  logic [7:0] regRdata;
  logic       upperEventPin;
  logic       lowerEventPin;
  logic       gateInterruptPin;
  logic       pwmGateOutput;
  logic       overflowIrq;
  logic       gateIrq;
  logic [7:0] expQ[$];
  logic       rdSeen   = 1'b0;
  int         badCount = 0;
  int         checks   = 0;
  int         cyc      = 0;
  int         seed     = 32'hc7d9;
  int         n;
  int         w;

  always #4 clock = ~clock;

  async_event_counter dut
  (
    .clock(clock), .rst_n(rst_n), .ce(ce), .regReq(regReq),
    .regRdata(regRdata), .upperEventPin(upperEventPin),
    .lowerEventPin(lowerEventPin), .gateInterruptPin(gateInterruptPin),
    .pwmGateOutput(pwmGateOutput), .overflowIrq(overflowIrq),
    .gateIrq(gateIrq)
  );

  event_source src
  (
    .clock(clock), .upperEventPin(upperEventPin),
    .lowerEventPin(lowerEventPin), .gateInterruptPin(gateInterruptPin),
    .pwmGateOutput(pwmGateOutput)
  );

  // ==========================================================
  // Checking
  task automatic final_report;
    if (badCount == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic cmpData(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e)
    begin
      badCount++;
      $display("[FAIL] %0t read %h expected %h", $time, got, e);
    end
  endtask : cmpData

  task automatic cmpIrq(input logic got, input logic e);
    checks++;
    if (got !== e)
    begin
      badCount++;
      $display("[FAIL] %0t irq %b expected %b", $time, got, e);
    end
  endtask : cmpIrq

  // Read data stand only in the cycle after the strobe
  always @(posedge clock)
  begin
    if (rdSeen)
      cmpData(regRdata, expQ.pop_front());
    rdSeen <= regReq.rd & ce;
    cyc++;
    if (cyc == 20000)
    begin
      badCount++;
      final_report();
    end
  end

  // ==========================================================
  // Bus tasks; idle cycle after each so no signal is set twice
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    regReq <= '0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    regReq <= '0;
    @(posedge clock);
  endtask : rd

  task automatic idle(input int k);
    repeat (k) @(posedge clock);
  endtask : idle

  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++)
      rd(a[2:0], (a == 5) ? CLK_STOP_ONES : RST_ZERO);
    n = 1 + ({$random(seed)} % 20);
    w = 2 + ({$random(seed)} % 2);
    wr(ADDR_CTRL_STAT, 8'h0f);
    src.pulse(1'b0, n, w);
    idle(5);
    rd(ADDR_LOWER_CNT, n[7:0]);
    wr(ADDR_CTRL_STAT, 8'h0b);
    src.pulse(1'b0, 3, 2);
    idle(5);
    rd(ADDR_LOWER_CNT, n[7:0]);
    wr(ADDR_CTRL_STAT, 8'h0e);
    rd(ADDR_LOWER_CNT, 8'h00);
    wr(ADDR_CTRL_STAT, 8'h0f);
    src.pulse(1'b0, 258, 2);
    idle(5);
    rd(ADDR_LOWER_CNT, 8'h02);
    rd(ADDR_UPPER_CNT, 8'h01);
    rd(ADDR_CTRL_STAT, 8'h0f);
    wr(ADDR_LOWER_CNT, 8'h55);
    rd(ADDR_LOWER_CNT, 8'h02);
    wr(ADDR_CTRL_STAT, 8'h07);
    src.pulse(1'b0, 256, 2);
    idle(5);
    rd(ADDR_UPPER_CNT, 8'h01);
    wr(ADDR_CTRL_STAT, 8'h0d);
    rd(ADDR_UPPER_CNT, 8'h00);
    // Split mode, upper pin on rising edge
    wr(ADDR_EDGE_SEL, 8'h40);
    wr(ADDR_CTRL_STAT, 8'h10);
    wr(ADDR_CTRL_STAT, 8'h1f);
    src.pulse(1'b1, n, w);
    src.pulse(1'b0, 256, 2);
    idle(5);
    rd(ADDR_UPPER_CNT, n[7:0]);
    rd(ADDR_LOWER_CNT, 8'h00);
    rd(ADDR_IRQ, 8'h01);
    cmpIrq(overflowIrq, 1'b0);
    wr(ADDR_IRQ, 8'h03);
    cmpIrq(overflowIrq, 1'b1);
    wr(ADDR_IRQ, 8'h02);
    cmpIrq(overflowIrq, 1'b0);
    // Flag needs a read of one before a zero write clears it
    wr(ADDR_CTRL_STAT, 8'h1f);
    rd(ADDR_CTRL_STAT, 8'h5f);
    wr(ADDR_CTRL_STAT, 8'hdf);
    rd(ADDR_CTRL_STAT, 8'h5f);
    wr(ADDR_CTRL_STAT, 8'h1f);
    rd(ADDR_CTRL_STAT, 8'h1f);
    src.pulse(1'b1, 256 - n, w);
    idle(5);
    rd(ADDR_UPPER_CNT, 8'h00);
    rd(ADDR_CTRL_STAT, 8'h9f);
    for (int e = 0; e < 3; e++)
    begin
      wr(ADDR_EDGE_SEL, {2'h0, e[1:0], 4'h0});
      wr(ADDR_CTRL_STAT, 8'h1e);
      wr(ADDR_CTRL_STAT, 8'h1f);
      src.pulse(1'b0, 3, 2);
      idle(5);
      rd(ADDR_LOWER_CNT, (e == 2) ? 8'h06 : 8'h03);
    end
    // Gate edges; lower pin counts both edges here
    for (int g = 0; g < 3; g++)
    begin
      wr(ADDR_EDGE_SEL, {2'h0, 2'h2, g[1:0], 2'h0});
      wr(ADDR_IRQ, 8'h08);
      cmpIrq(gateIrq, 1'b0);
      src.setGate(1'b0, 1'b1);
      idle(4);
      rd(ADDR_IRQ, (g == 1) ? 8'h08 : 8'h0c);
      src.pulse(1'b0, 2, 2);
      idle(5);
      rd(ADDR_LOWER_CNT, 8'h06);
      src.setGate(1'b1, 1'b1);
      idle(5);
      rd(ADDR_IRQ, 8'h0c);
      cmpIrq(gateIrq, 1'b1);
    end
    wr(ADDR_EDGE_SEL, 8'h22);
    src.setGate(1'b1, 1'b0);
    idle(4);
    src.pulse(1'b0, 2, 2);
    idle(5);
    rd(ADDR_LOWER_CNT, 8'h06);
    src.setGate(1'b0, 1'b1);
    idle(4);
    src.pulse(1'b0, 1, 2);
    idle(5);
    rd(ADDR_LOWER_CNT, 8'h08);
    src.setGate(1'b1, 1'b1);
    // Standby keeps contents and ignores control writes
    wr(ADDR_CLK_STOP, 8'hf7);
    rd(ADDR_CLK_STOP, 8'hf7);
    src.pulse(1'b0, 2, 2);
    wr(ADDR_CTRL_STAT, 8'h10);
    wr(ADDR_CLK_STOP, 8'hff);
    idle(5);
    rd(ADDR_LOWER_CNT, 8'h08);
    rd(ADDR_CTRL_STAT, 8'h1f);
    ce <= 1'b0;
    wr(ADDR_CTRL_STAT, 8'h00);
    ce <= 1'b1;
    rd(ADDR_CTRL_STAT, 8'h1f);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rd(ADDR_CTRL_STAT, 8'h00);
    rd(ADDR_UPPER_CNT, 8'h00);
    idle(2);
    final_report();
  end

endmodule : tb_top

// [logic/async_event_counter.sv]
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module async_event_counter
(
  // Clock and reset
  input  wire  logic                         clock,
  input  wire  logic                         rst_n,
  input  wire  logic                         ce,
  // Register port
  input  wire  event_counter_pkg::reg_req_s  regReq,
  output logic [7:0]                         regRdata,
  // Event and gate inputs
  input  wire  logic                         upperEventPin,
  input  wire  logic                         lowerEventPin,
  input  wire  logic                         gateInterruptPin,
  input  wire  logic                         pwmGateOutput,
  // Interrupt requests
  output logic                               overflowIrq,
  output logic                               gateIrq
);
  import event_counter_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] edgeSelReg;
  logic [7:0] clkCtrlReg;
  logic [7:0] ctrlReg;
  logic [7:0] clkStopReg;
  logic [7:0] upperCntReg;
  logic [7:0] lowerCntReg;
  logic       ovUpperReg;
  logic       ovLowerReg;
  logic       ovUpperArmReg;
  logic       ovLowerArmReg;
  logic       ovReqReg;
  logic       ovIenReg;
  logic       gateReqReg;
  logic       gateIenReg;
  logic [PRESCALE_W-1:0] prescaleReg;
  logic [2:0] syncAReg;
  logic [2:0] syncBReg;
  logic [2:0] pinPrevReg;

  logic run;
  logic wrEdge, wrClk, wrCtrl, wrStop, wrIrq, rdCtrl;
  logic [2:0] pinEdge;
  logic [1:0] selEdge [3];
  logic [2:0] divTick;
  logic gateOpen;
  logic lowerInc, upperInc, lowerWrap, upperWrap;
  logic splitMode;

  // Standby freezes counting, control writes and overflow flag clears; reads and standby and interrupt writes still work
  assign run       = ce & clkStopReg[STBY_CLR_BIT];
  assign splitMode = ctrlReg[SPLIT_BIT];
  assign wrEdge    = ce & regReq.wr & (regReq.addr == ADDR_EDGE_SEL);
  assign wrClk     = ce & regReq.wr & (regReq.addr == ADDR_CLK_CTRL);
  assign wrCtrl    = ce & regReq.wr & (regReq.addr == ADDR_CTRL_STAT);
  assign wrStop    = ce & regReq.wr & (regReq.addr == ADDR_CLK_STOP);
  assign wrIrq     = ce & regReq.wr & (regReq.addr == ADDR_IRQ);
  assign rdCtrl    = ce & regReq.rd & (regReq.addr == ADDR_CTRL_STAT);

  // ==========================================================
  // Pin synchronisers and edge detection, index 0 upper,
  // 1 lower, 2 gate
  assign selEdge[0] = edgeSelReg[UPPER_SEL_LSB +: 2];
  assign selEdge[1] = edgeSelReg[LOWER_SEL_LSB +: 2];
  assign selEdge[2] = edgeSelReg[GATE_SEL_LSB +: 2];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncAReg   <= 3'h0;
      syncBReg   <= 3'h0;
      pinPrevReg <= 3'h0;
    end
    else if (ce)
    begin
      syncAReg   <= {gateInterruptPin, lowerEventPin, upperEventPin};
      syncBReg   <= syncAReg;
      pinPrevReg <= syncBReg;
    end
  end

  // Prohibited code 11 senses nothing
  for (genvar i = 0; i < 3; i++)
  begin : g_edge
    logic rise, fall;
    assign rise = syncBReg[i] & ~pinPrevReg[i];
    assign fall = ~syncBReg[i] & pinPrevReg[i];
    assign pinEdge[i] = ((selEdge[i] == EDGE_FALL) & fall)
                      | ((selEdge[i] == EDGE_RISE) & rise)
                      | ((selEdge[i] == EDGE_BOTH) & (rise | fall));
  end

  // ==========================================================
  // Divided system clock ticks
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      prescaleReg <= '0;
    else if (run)
      prescaleReg <= prescaleReg + 1'b1;
  end

  for (genvar d = 0; d < PRESCALE_W; d++)
  begin : g_div
    assign divTick[d] = &prescaleReg[d:0];
  end

  function automatic logic pickSrc(input logic [1:0] sel,
                                   input logic pin,
                                   input logic [2:0] tick);
    pickSrc = (sel == SRC_PIN)  ? pin :
              (sel == SRC_DIV2) ? tick[0] :
              (sel == SRC_DIV4) ? tick[1] : tick[2];
  endfunction : pickSrc

  // ==========================================================
  // Count gating and increments
  assign gateOpen = edgeSelReg[PWM_EN_BIT] ? pwmGateOutput
                                           : syncBReg[2];

  assign lowerInc = run & gateOpen & ctrlReg[LOW_EN_BIT]
                  & ctrlReg[LOW_REL_BIT]
                  & pickSrc(clkCtrlReg[LOWER_SEL_LSB +: 2],
                            pinEdge[1], divTick);
  assign lowerWrap = lowerInc & (lowerCntReg == COUNT_MAX);

  // Chained: upper counts low wraps, its own source otherwise
  assign upperInc = run & gateOpen & ctrlReg[UP_EN_BIT]
                  & ctrlReg[UP_REL_BIT]
                  & (splitMode
                     ? pickSrc(clkCtrlReg[UPPER_SEL_LSB +: 2],
                               pinEdge[0], divTick)
                     : lowerWrap);
  assign upperWrap = upperInc & (upperCntReg == COUNT_MAX);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      lowerCntReg <= RST_ZERO;
    else if (run)
    begin
      if (!ctrlReg[LOW_REL_BIT])
        lowerCntReg <= RST_ZERO;
      else if (lowerInc)
        lowerCntReg <= lowerCntReg + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      upperCntReg <= RST_ZERO;
    else if (run)
    begin
      if (!ctrlReg[UP_REL_BIT])
        upperCntReg <= RST_ZERO;
      else if (upperInc)
        upperCntReg <= upperCntReg + 8'h01;
    end
  end

  // ==========================================================
  // Overflow flags: clear needs a prior read of the set flag,
  // and a new overflow wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovUpperReg    <= 1'b0;
      ovLowerReg    <= 1'b0;
      ovUpperArmReg <= 1'b0;
      ovLowerArmReg <= 1'b0;
    end
    else if (ce)
    begin
      if (rdCtrl)
      begin
        ovUpperArmReg <= ovUpperReg;
        ovLowerArmReg <= ovLowerReg;
      end
      if (upperWrap)
        ovUpperReg <= 1'b1;
      else if (run & wrCtrl & ovUpperArmReg
               & !regReq.wdata[OV_UPPER_BIT])
        ovUpperReg <= 1'b0;
      if (lowerWrap & splitMode)
        ovLowerReg <= 1'b1;
      else if (run & wrCtrl & ovLowerArmReg
               & !regReq.wdata[OV_LOWER_BIT])
        ovLowerReg <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers; only the standby and interrupt registers are
  // writable while in standby so settings stay retained
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      edgeSelReg <= RST_ZERO;
      clkCtrlReg <= RST_ZERO;
      ctrlReg    <= RST_ZERO;
      clkStopReg <= CLK_STOP_ONES;
    end
    else
    begin
      if (wrStop)
        clkStopReg <= regReq.wdata | ~(8'h01 << STBY_CLR_BIT);
      if (run & wrEdge)
        edgeSelReg <= regReq.wdata;
      if (run & wrClk)
        clkCtrlReg <= regReq.wdata;
      if (run & wrCtrl)
        ctrlReg <= {2'b00, regReq.wdata[5:0]};
    end
  end

  // ==========================================================
  // Interrupt request flags and enables
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovReqReg   <= 1'b0;
      ovIenReg   <= 1'b0;
      gateReqReg <= 1'b0;
      gateIenReg <= 1'b0;
    end
    else if (ce)
    begin
      if (wrIrq)
      begin
        ovIenReg   <= regReq.wdata[OV_IEN_BIT];
        gateIenReg <= regReq.wdata[GATE_IEN_BIT];
      end
      if (upperWrap | (lowerWrap & splitMode))
        ovReqReg <= 1'b1;
      else if (wrIrq & !regReq.wdata[OV_REQ_BIT])
        ovReqReg <= 1'b0;
      if (run & pinEdge[2])
        gateReqReg <= 1'b1;
      else if (wrIrq & !regReq.wdata[GATE_REQ_BIT])
        gateReqReg <= 1'b0;
    end
  end

  assign overflowIrq = ovReqReg & ovIenReg;
  assign gateIrq     = gateReqReg & gateIenReg;

  // ==========================================================
  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= RST_ZERO;
    else if (ce)
    begin
      unique case (regReq.addr)
        ADDR_EDGE_SEL:  regRdata <= edgeSelReg;
        ADDR_CLK_CTRL:  regRdata <= clkCtrlReg;
        ADDR_CTRL_STAT: regRdata <= {ovUpperReg, ovLowerReg, ctrlReg[5:0]};
        ADDR_UPPER_CNT: regRdata <= upperCntReg;
        ADDR_LOWER_CNT: regRdata <= lowerCntReg;
        ADDR_CLK_STOP:  regRdata <= clkStopReg;
        ADDR_IRQ:       regRdata <= {4'h0, gateIenReg, gateReqReg,
                                     ovIenReg, ovReqReg};
        default:        regRdata <= RST_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  sequence s_bothFull;
    !splitMode && upperInc && lowerCntReg == COUNT_MAX
      && upperCntReg == COUNT_MAX;
  endsequence

  sequence s_wrapped16;
    upperCntReg == 8'h00 && lowerCntReg == 8'h00 && ovUpperReg;
  endsequence

  property p_lowHold;
    @(posedge clock) disable iff (!rst_n)
    (run && ctrlReg[LOW_REL_BIT] && !ctrlReg[LOW_EN_BIT])
      |=> $stable(lowerCntReg);
  endproperty
  a_lowHold: assert property (p_lowHold)
    else $error("low counter moved while disabled");

  property p_lowRelease;
    @(posedge clock) disable iff (!rst_n)
    (run && !ctrlReg[LOW_REL_BIT]) |=> lowerCntReg == 8'h00;
  endproperty
  a_lowRelease: assert property (p_lowRelease)
    else $error("low counter not held in reset");

  property p_upRelease;
    @(posedge clock) disable iff (!rst_n)
    (run && !ctrlReg[UP_REL_BIT]) |=> upperCntReg == 8'h00;
  endproperty
  a_upRelease: assert property (p_upRelease)
    else $error("high counter not held in reset");

  property p_wrap16;
    @(posedge clock) disable iff (!rst_n)
    s_bothFull |=> s_wrapped16;
  endproperty
  a_wrap16: assert property (p_wrap16)
    else $error("16-bit wrap did not clear and flag");

  property p_wrap8;
    @(posedge clock) disable iff (!rst_n)
    (splitMode && lowerWrap) |=> (lowerCntReg == 8'h00 && ovLowerReg);
  endproperty
  a_wrap8: assert property (p_wrap8)
    else $error("8-bit low wrap did not flag");

  property p_gateBlock;
    @(posedge clock) disable iff (!rst_n)
    (!gateOpen && ctrlReg[LOW_REL_BIT] && ctrlReg[UP_REL_BIT])
      |=> ($stable(lowerCntReg) && $stable(upperCntReg));
  endproperty
  a_gateBlock: assert property (p_gateBlock)
    else $error("count passed a closed gate");

  property p_standby;
    @(posedge clock) disable iff (!rst_n)
    !clkStopReg[STBY_CLR_BIT] |=> ($stable(lowerCntReg)
                                  && $stable(upperCntReg));
  endproperty
  a_standby: assert property (p_standby)
    else $error("counter moved in standby");

  property p_ovReq;
    @(posedge clock) disable iff (!rst_n)
    (ce && upperWrap) |=> (ovReqReg && (overflowIrq == ovIenReg));
  endproperty
  a_ovReq: assert property (p_ovReq)
    else $error("overflow request not raised");

  property p_ovSetOnly;
    @(posedge clock) disable iff (!rst_n)
    $rose(ovUpperReg) |-> $past(upperWrap);
  endproperty
  a_ovSetOnly: assert property (p_ovSetOnly)
    else $error("high overflow set without wrap");

  property p_gateEdge;
    @(posedge clock) disable iff (!rst_n)
    (run && pinEdge[2]) |=> gateReqReg;
  endproperty
  a_gateEdge: assert property (p_gateEdge)
    else $error("gate edge not flagged");

endmodule : async_event_counter

// [logic/event_counter_pkg.sv]
// What this block does
// - Low count enable gates low counter clocks
// - High release bit zero holds high counter
// - Low release bit zero holds low counter
// - High counter: read-only, pin, divided clock or low overflow
// - Low counter: read-only, pin or divided clock
// - Standby bit zero puts block in standby
// - Split bit zero chains one 16-bit counter
// - 16-bit wrap sets high overflow flag
// - Overflow sets request; enable forwards interrupt
// - Split bit one: independent counters, own selects
// - Each event pin uses its edge select
// - 8-bit wrap sets own overflow flag
// - Gate pin high passes clocks, low blocks
// - Gate pin edge sets gate request flag
// - Gate edge: rising, falling or both
// - Reset gives 16-bit, low pin, falling edge
// - Overflow flags: hardware sets, read-then-zero clears
// - PWM gate enabled: PWM output gates clocks
// - High count enable gates high counter clocks
package event_counter_pkg;

  // ==========================================================
  // Register map, one byte per address
  localparam logic [2:0] ADDR_EDGE_SEL   = 3'h0;
  localparam logic [2:0] ADDR_CLK_CTRL   = 3'h1;
  localparam logic [2:0] ADDR_CTRL_STAT  = 3'h2;
  localparam logic [2:0] ADDR_UPPER_CNT  = 3'h3;
  localparam logic [2:0] ADDR_LOWER_CNT  = 3'h4;
  localparam logic [2:0] ADDR_CLK_STOP   = 3'h5;
  localparam logic [2:0] ADDR_IRQ        = 3'h6;

  // ==========================================================
  // Field positions
  localparam int UPPER_SEL_LSB   = 6;
  localparam int LOWER_SEL_LSB   = 4;
  localparam int GATE_SEL_LSB    = 2;
  localparam int PWM_EN_BIT      = 1;
  localparam int OV_UPPER_BIT    = 7;
  localparam int OV_LOWER_BIT    = 6;
  localparam int SPLIT_BIT       = 4;
  localparam int UP_EN_BIT       = 3;
  localparam int LOW_EN_BIT      = 2;
  localparam int UP_REL_BIT      = 1;
  localparam int LOW_REL_BIT     = 0;
  localparam int STBY_CLR_BIT    = 3;
  localparam int OV_REQ_BIT      = 0;
  localparam int OV_IEN_BIT      = 1;
  localparam int GATE_REQ_BIT    = 2;
  localparam int GATE_IEN_BIT    = 3;

  // ==========================================================
  // Reset values and encodings
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] CLK_STOP_ONES = 8'hff;
  localparam logic [7:0] COUNT_MAX     = 8'hff;
  localparam logic [1:0] SRC_PIN       = 2'h0;
  localparam logic [1:0] SRC_DIV2      = 2'h1;
  localparam logic [1:0] SRC_DIV4      = 2'h2;
  localparam logic [1:0] EDGE_FALL     = 2'h0;
  localparam logic [1:0] EDGE_RISE     = 2'h1;
  localparam logic [1:0] EDGE_BOTH     = 2'h2;
  localparam int         PRESCALE_W    = 3;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

endpackage : event_counter_pkg
